// file: shared/status_defines.svh
`ifndef STATUS_DEFINES_SVH
`define STATUS_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets on the parallel control port
// ----------------------------------------------------------------
`define OFF_SYNC_STATUS  8'h18
`define OFF_SYNC_MASK    8'h19
`define OFF_COND_STATUS  8'h1A
`define OFF_COND_MASK    8'h1B
`define OFF_EVT_STATUS   8'h1C
`define OFF_EVT_MASK     8'h1D
`define OFF_COMMON_CTRL  8'h70

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define REG_RESET        8'h00
`define POS_PIN_SELECT   0
`define POS_SR2_CARRIER  1
`define POS_EVT_RX_MF    2
`define POS_DMA_BIT      2

// ----------------------------------------------------------------
// timing: one channel time is eight bit periods of the line
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    25
`define CHAN_TIME_E1_NS  3906
`define CHAN_TIME_T1_NS  5181
`define CHAN_CYC_E1      ((`CHAN_TIME_E1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CHAN_CYC_T1      ((`CHAN_TIME_T1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// frames per multiframe and detector thresholds
// ----------------------------------------------------------------
`define MF_LEN_E1        5'd16
`define MF_LEN_D4        5'd12
`define MF_LEN_ESF       5'd24
`define SIG_ONES_ZEROS   8'd3
`define ZERO_SAT         8'hF8

`endif

// file: shared/status_pkg.sv
package status_pkg;

    // one register of the control port
    typedef logic [7:0] reg8_t;

    // line framing format, one-hot
    typedef enum logic [2:0] {
        FMT_T1_D4  = 3'b001,
        FMT_T1_ESF = 3'b010,
        FMT_E1     = 3'b100
    } line_format_t;

endpackage

// file: core/clock_loss_watch.sv
`timescale 1ns/1ps
`include "status_defines.svh"
module clock_loss_watch #(
    parameter int unsigned LIMIT_E1 = `CHAN_CYC_E1,
    parameter int unsigned LIMIT_T1 = `CHAN_CYC_T1
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic lineClock,
    input  wire logic e1Mode,
    output logic      clockLost
);
    logic       syncA_r;
    logic       syncB_r;
    logic       last_r;
    logic [8:0] idle_r;
    logic [8:0] idle_nxt;
    logic       lost_r;
    logic       lost_nxt;
    logic [8:0] limit;

    assign limit     = e1Mode ? 9'(LIMIT_E1) : 9'(LIMIT_T1);
    assign clockLost = lost_r;

    // idle time since the last seen transition of the line clock
    always_comb begin
        idle_nxt = idle_r;
        lost_nxt = lost_r;
        if (syncB_r != last_r) begin
            idle_nxt = 9'd0;
            lost_nxt = 1'b0;
        end else if (idle_r >= limit - 9'd1) begin
            lost_nxt = 1'b1;
        end else begin
            idle_nxt = idle_r + 9'd1;
        end
    end

    // two-stage synchroniser; edges only seen past the second stage
    always_ff @(posedge clk) begin
        syncA_r <= lineClock;
        syncB_r <= syncA_r;
        last_r  <= syncB_r;
        if (reset) begin
            idle_r <= 9'd0;
            lost_r <= 1'b0;
        end else begin
            idle_r <= idle_nxt;
            lost_r <= lost_nxt;
        end
    end

    a_idle_timeout: assert property (
        @(posedge clk) disable iff (reset)
        (idle_r >= limit - 9'd1) && (syncB_r == last_r) |=> clockLost)
        else $error("line clock idle for a channel time without loss flag");

    a_edge_restores: assert property (
        @(posedge clk) disable iff (reset)
        (syncB_r != last_r) |=> !clockLost && idle_r == 9'd0)
        else $error("loss flag held after a clock transition");
endmodule

// file: core/frame_counter.sv
`timescale 1ns/1ps
`include "status_defines.svh"
module frame_counter
    import status_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         frameStrobe,
    input  wire logic         mfStart,
    input  wire line_format_t format,
    output logic [4:0]        frameNum,
    output logic              alignPulse,
    output logic              mfPulse
);
    logic [4:0] num_r;
    logic [4:0] num_nxt;
    logic [4:0] mfLen;
    logic       align_r;
    logic       align_nxt;
    logic       mf_r;
    logic       mf_nxt;

    assign frameNum   = num_r;
    assign alignPulse = align_r;
    assign mfPulse    = mf_r;

    // frames per multiframe for the framing format
    always_comb begin
        case (format)
            FMT_E1:     mfLen = `MF_LEN_E1;
            FMT_T1_ESF: mfLen = `MF_LEN_ESF;
            default:    mfLen = `MF_LEN_D4;
        endcase
    end

    // frame count; a boundary strobe from the framer re-aligns it
    always_comb begin
        num_nxt   = num_r;
        align_nxt = 1'b0;
        mf_nxt    = 1'b0;
        if (frameStrobe) begin
            if (mfStart || num_r >= mfLen - 5'd1) begin
                num_nxt = 5'd0;
            end else begin
                num_nxt = num_r + 5'd1;
            end
            mf_nxt    = (num_nxt == 5'd0);
            align_nxt = (format == FMT_E1) && !num_nxt[0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            num_r   <= 5'd0;
            align_r <= 1'b0;
            mf_r    <= 1'b0;
        end else begin
            num_r   <= num_nxt;
            align_r <= align_nxt;
            mf_r    <= mf_nxt;
        end
    end
endmodule

// file: core/framer_alarm_event_status.sv
`timescale 1ns/1ps
`include "status_defines.svh"
module framer_alarm_event_status
    import status_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] addr,
    input  wire logic       wrEn,
    input  wire logic       rdEn,
    input  wire logic [7:0] wrData,
    output logic      [7:0] rdData,
    input  wire logic       e1Mode,
    input  wire logic       esfMode,
    input  wire logic       crc4Enable,
    input  wire logic       syncLossCond,
    input  wire logic       carrierLossCond,
    input  wire logic       unframedOnesCond,
    input  wire logic       yellowAlarmCond,
    input  wire logic       rxNfasStrobe,
    input  wire logic       rxNfasBit3,
    input  wire logic       rxSa7Strobe,
    input  wire logic       rxSa7Bit,
    input  wire logic       rxTs16Strobe,
    input  wire logic [7:0] rxTs16Byte,
    input  wire logic       rxFrameStrobe,
    input  wire logic       rxMfStart,
    input  wire logic       rxCrcMfBoundary,
    input  wire logic       txFrameStrobe,
    input  wire logic       txMfStart,
    input  wire logic       loopUpCodeCond,
    input  wire logic       loopDownCodeCond,
    input  wire logic       spareCodeCond,
    input  wire logic       rxAisCiEvt,
    input  wire logic       rxLineClockIn,
    input  wire logic       txLineClock,
    output logic            lossPin,
    output logic            intRequest
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    line_format_t fmt;
    logic [4:0]   rxFrameNum;
    logic         rxAlignPulse;
    logic         rxMfPulse;
    logic         txAlignPulse;
    logic         txMfPulse;
    logic         rxClockLost;
    logic         txClockLost;
    logic [2:0]   nfasHist_r,  nfasHist_nxt;
    logic         remote_r,    remote_nxt;
    logic [1:0]   dmaHist_r,   dmaHist_nxt;
    logic [2:0]   sa7Hist_r,   sa7Hist_nxt;
    logic         ts16Or_r,    ts16Or_nxt;
    logic [7:0]   ts16Zeros_r, ts16Zeros_nxt;
    logic         sigZerosHit;
    logic         sigOnesHit;
    reg8_t        syncMask_r,  syncMask_nxt;
    reg8_t        condMask_r,  condMask_nxt;
    reg8_t        evtMask_r,   evtMask_nxt;
    logic         pinSel_r,    pinSel_nxt;
    logic [3:0]   clearEvt_r,  clearEvt_nxt;
    logic [3:0]   prev2_r;
    reg8_t        prev3_r;
    reg8_t        pend2_r,     pend2_nxt;
    reg8_t        pend3_r,     pend3_nxt;
    reg8_t        evt_r,       evt_nxt;
    reg8_t        rdData_r,    rdData_nxt;
    logic         lossPin_r,   lossPin_nxt;
    logic         irq_r,       irq_nxt;
    logic [3:0]   cond2;
    logic [3:0]   fall2;
    logic [3:0]   rise2;
    reg8_t        cond3;
    reg8_t        evtSet4;
    logic         v5Link;
    logic         crcMfEvt;
    logic         rdSyncSt;
    logic         rdCondSt;
    logic         rdEvtSt;

    // zeros in one timeslot byte
    function automatic logic [3:0] zeroCount(input logic [7:0] b);
        logic [3:0] n;
        n = 4'd0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'd0, ~b[i]};
        end
        return n;
    endfunction

    // ----------------------------------------------------------------
    // frame timing and clock watchdogs
    // ----------------------------------------------------------------
    assign fmt = e1Mode ? FMT_E1 : (esfMode ? FMT_T1_ESF : FMT_T1_D4);

    frame_counter rxFrames (
        .clk         (clk),
        .reset       (reset),
        .frameStrobe (rxFrameStrobe),
        .mfStart     (rxMfStart),
        .format      (fmt),
        .frameNum    (rxFrameNum),
        .alignPulse  (rxAlignPulse),
        .mfPulse     (rxMfPulse)
    );

    frame_counter txFrames (
        .clk         (clk),
        .reset       (reset),
        .frameStrobe (txFrameStrobe),
        .mfStart     (txMfStart),
        .format      (fmt),
        .frameNum    (),
        .alignPulse  (txAlignPulse),
        .mfPulse     (txMfPulse)
    );

    clock_loss_watch rxWatch (
        .clk       (clk),
        .reset     (reset),
        .lineClock (rxLineClockIn),
        .e1Mode    (e1Mode),
        .clockLost (rxClockLost)
    );

    clock_loss_watch txWatch (
        .clk       (clk),
        .reset     (reset),
        .lineClock (txLineClock),
        .e1Mode    (e1Mode),
        .clockLost (txClockLost)
    );

    // ----------------------------------------------------------------
    // E1 line detectors
    // ----------------------------------------------------------------
    // any two of the last three Sa7 bits at zero
    assign v5Link = (~sa7Hist_r[0] & ~sa7Hist_r[1]) | (~sa7Hist_r[0] & ~sa7Hist_r[2])
                  | (~sa7Hist_r[1] & ~sa7Hist_r[2]);

    // detector next values; the TS16 windows close on each rx multiframe
    always_comb begin
        nfasHist_nxt  = nfasHist_r;
        remote_nxt    = remote_r;
        dmaHist_nxt   = dmaHist_r;
        sa7Hist_nxt   = sa7Hist_r;
        sigZerosHit   = rxMfPulse && !ts16Or_r;
        sigOnesHit    = rxMfPulse && (ts16Zeros_r < `SIG_ONES_ZEROS);
        ts16Or_nxt    = rxMfPulse ? 1'b0 : ts16Or_r;
        ts16Zeros_nxt = rxMfPulse ? 8'd0 : ts16Zeros_r;
        if (rxNfasStrobe) begin
            nfasHist_nxt = {nfasHist_r[1:0], rxNfasBit3};
            if (nfasHist_nxt == 3'b111) begin
                remote_nxt = 1'b1;
            end else if (nfasHist_nxt == 3'b000) begin
                remote_nxt = 1'b0;
            end
        end
        if (rxSa7Strobe) begin
            sa7Hist_nxt = {sa7Hist_r[1:0], rxSa7Bit};
        end
        // kept in CCS mode too: nothing here looks at the signaling mode
        if (rxTs16Strobe && rxFrameNum == 5'd0) begin
            dmaHist_nxt = {dmaHist_r[0], rxTs16Byte[`POS_DMA_BIT]};
        end
        if (rxTs16Strobe) begin
            ts16Or_nxt = ts16Or_nxt | (|rxTs16Byte);
            if (ts16Zeros_nxt < `ZERO_SAT) begin
                ts16Zeros_nxt = ts16Zeros_nxt + {4'd0, zeroCount(rxTs16Byte)};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            nfasHist_r  <= 3'd0;
            remote_r    <= 1'b0;
            dmaHist_r   <= 2'd0;
            sa7Hist_r   <= 3'b111;
            ts16Or_r    <= 1'b0;
            ts16Zeros_r <= 8'd0;
        end else begin
            nfasHist_r  <= nfasHist_nxt;
            remote_r    <= remote_nxt;
            dmaHist_r   <= dmaHist_nxt;
            sa7Hist_r   <= sa7Hist_nxt;
            ts16Or_r    <= ts16Or_nxt;
            ts16Zeros_r <= ts16Zeros_nxt;
        end
    end

    // ----------------------------------------------------------------
    // status sources
    // ----------------------------------------------------------------
    // E1-only and T1-only sources forced low in the other mode
    assign cond2 = {yellowAlarmCond & ~e1Mode, unframedOnesCond, carrierLossCond,
                    syncLossCond};
    assign cond3 = {spareCodeCond & ~e1Mode, loopDownCodeCond & ~e1Mode,
                    loopUpCodeCond & ~e1Mode, txClockLost, rxClockLost,
                    v5Link & e1Mode, (&dmaHist_r) & e1Mode, remote_r & e1Mode};
    assign crcMfEvt = e1Mode & (crc4Enable ? rxCrcMfBoundary : rxMfPulse);
    assign evtSet4  = {rxAisCiEvt & ~e1Mode, sigOnesHit & e1Mode, sigZerosHit & e1Mode,
                       txMfPulse, txAlignPulse, rxMfPulse, crcMfEvt, rxAlignPulse};
    assign fall2 = prev2_r & ~cond2;
    assign rise2 = cond2 & ~prev2_r;
    assign rdSyncSt = rdEn && addr == `OFF_SYNC_STATUS;
    assign rdCondSt = rdEn && addr == `OFF_COND_STATUS;
    assign rdEvtSt  = rdEn && addr == `OFF_EVT_STATUS;

    // ----------------------------------------------------------------
    // register file and interrupt request
    // ----------------------------------------------------------------
    // a set in the cycle of a clearing read wins, so no event is lost
    always_comb begin
        syncMask_nxt = syncMask_r;
        condMask_nxt = condMask_r;
        evtMask_nxt  = evtMask_r;
        pinSel_nxt   = pinSel_r;
        rdData_nxt   = rdData_r;
        clearEvt_nxt = (clearEvt_r & {4{~rdSyncSt}}) | fall2;
        pend2_nxt    = (pend2_r & {8{~rdSyncSt}}) | ({fall2, rise2} & syncMask_r);
        pend3_nxt    = (pend3_r & {8{~rdCondSt}}) | ((cond3 ^ prev3_r) & condMask_r);
        evt_nxt      = (evt_r & {8{~rdEvtSt}}) | evtSet4;
        if (wrEn) begin
            if (addr == `OFF_SYNC_MASK) begin
                syncMask_nxt = wrData;
            end else if (addr == `OFF_COND_MASK) begin
                condMask_nxt = wrData;
            end else if (addr == `OFF_EVT_MASK) begin
                evtMask_nxt = wrData;
            end else if (addr == `OFF_COMMON_CTRL) begin
                pinSel_nxt = wrData[`POS_PIN_SELECT];
            end
        end
        if (rdEn) begin
            if (addr == `OFF_SYNC_STATUS) begin
                rdData_nxt = {clearEvt_r, cond2};
            end else if (addr == `OFF_SYNC_MASK) begin
                rdData_nxt = syncMask_r;
            end else if (addr == `OFF_COND_STATUS) begin
                rdData_nxt = cond3;
            end else if (addr == `OFF_COND_MASK) begin
                rdData_nxt = condMask_r;
            end else if (addr == `OFF_EVT_STATUS) begin
                rdData_nxt = evt_r;
            end else if (addr == `OFF_EVT_MASK) begin
                rdData_nxt = evtMask_r;
            end else if (addr == `OFF_COMMON_CTRL) begin
                rdData_nxt = {7'd0, pinSel_r};
            end else begin
                rdData_nxt = `REG_RESET;
            end
        end
        // mask gates the output too, so clearing a mask drops the request
        irq_nxt = (|(pend2_nxt & syncMask_nxt)) | (|(pend3_nxt & condMask_nxt))
                | (|(evt_nxt & evtMask_nxt));
        lossPin_nxt = pinSel_r ? txClockLost : syncLossCond;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            syncMask_r <= `REG_RESET;
            condMask_r <= `REG_RESET;
            evtMask_r  <= `REG_RESET;
            pinSel_r   <= 1'b0;
            clearEvt_r <= 4'd0;
            prev2_r    <= 4'd0;
            prev3_r    <= `REG_RESET;
            pend2_r    <= `REG_RESET;
            pend3_r    <= `REG_RESET;
            evt_r      <= `REG_RESET;
            rdData_r   <= `REG_RESET;
            lossPin_r  <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            syncMask_r <= syncMask_nxt;
            condMask_r <= condMask_nxt;
            evtMask_r  <= evtMask_nxt;
            pinSel_r   <= pinSel_nxt;
            clearEvt_r <= clearEvt_nxt;
            prev2_r    <= cond2;
            prev3_r    <= cond3;
            pend2_r    <= pend2_nxt;
            pend3_r    <= pend3_nxt;
            evt_r      <= evt_nxt;
            rdData_r   <= rdData_nxt;
            lossPin_r  <= lossPin_nxt;
            irq_r      <= irq_nxt;
        end
    end

    assign rdData     = rdData_r;
    assign lossPin    = lossPin_r;
    assign intRequest = irq_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence threeOnes;
        e1Mode && rxNfasStrobe && rxNfasBit3 && nfasHist_r[1:0] == 2'b11 ##1 e1Mode;
    endsequence

    sequence secondDmaSet;
        e1Mode && rxTs16Strobe && rxFrameNum == 5'd0 && rxTs16Byte[`POS_DMA_BIT]
            && dmaHist_r[0] ##1 e1Mode;
    endsequence

    sequence quietRead;
        rdEvtSt && evtSet4 == 8'h00 && syncMask_r == 8'h00 && condMask_r == 8'h00 && !wrEn;
    endsequence

    a_rise_irq: assert property (
        $rose(carrierLossCond) && syncMask_r[`POS_SR2_CARRIER] && !wrEn |=> intRequest)
        else $error("rising carrier loss did not raise the request");

    a_fall_quiet: assert property (
        $fell(carrierLossCond) && !pend2_r[`POS_SR2_CARRIER]
            |=> !pend2_r[`POS_SR2_CARRIER])
        else $error("falling carrier loss raised a pending edge");

    a_clear_latch: assert property (
        $fell(carrierLossCond) |=> clearEvt_r[`POS_SR2_CARRIER])
        else $error("carrier loss clear event not latched");

    a_remote_set: assert property (
        threeOnes |-> cond3[0])
        else $error("remote alarm not set after three ones");

    a_dma_set: assert property (
        secondDmaSet |-> cond3[1])
        else $error("distant multiframe alarm not set");

    a_loss_pin: assert property (
        pinSel_r && txClockLost |=> lossPin)
        else $error("loss pin low during transmit clock loss");

    a_both_edges: assert property (
        (|((cond3 ^ prev3_r) & condMask_r)) && !wrEn |=> intRequest)
        else $error("condition edge did not raise the request");

    a_masks_gate: assert property (
        syncMask_r == 8'h00 && condMask_r == 8'h00 && evtMask_r == 8'h00 |-> !intRequest)
        else $error("request raised with every mask cleared");

    a_evt_sticky: assert property (
        evt_r[`POS_EVT_RX_MF] && !rdEvtSt |=> evt_r[`POS_EVT_RX_MF])
        else $error("latched event dropped without a read");

    a_read_release: assert property (
        quietRead |=> !intRequest && evt_r == 8'h00)
        else $error("request held after all sources were read");
endmodule

// file: tb/host_port_model.sv
`timescale 1ns/1ps
module host_port_model
    import status_pkg::*;
(
    input  wire logic       clk,
    output logic      [7:0] addr,
    output logic            wrEn,
    output logic            rdEn,
    output logic      [7:0] wrData,
    input  wire logic [7:0] rdData
);
    // ----------------------------------------------------------------
    // host side of the parallel control port
    // ----------------------------------------------------------------
    initial begin
        addr = 8'h00;
        wrEn = 1'b0;
        rdEn = 1'b0;
        wrData = 8'h00;
    end

    // one strobe per access; a released bus shows the inverse, not the old value
    task automatic write_reg(input reg8_t a, input reg8_t d);
        @(posedge clk);
        #1;
        addr = a;
        wrData = d;
        wrEn = 1'b1;
        @(posedge clk);
        #1;
        wrEn = 1'b0;
        addr = ~a;
        wrData = ~d;
    endtask

    // data is taken one edge after the strobe edge, while it still holds
    task automatic read_reg(input reg8_t a, output reg8_t d);
        @(posedge clk);
        #1;
        addr = a;
        rdEn = 1'b1;
        @(posedge clk);
        #1;
        rdEn = 1'b0;
        addr = ~a;
        @(posedge clk);
        #1;
        d = rdData;
    endtask
endmodule

// file: tb/framer_alarm_event_status_bench.sv
`timescale 1ns/1ps
module framer_alarm_event_status_bench
    import status_pkg::*;
;
    logic clk = 1'b0, reset = 1'b1, ckRun = 1'b1, lineCk = 1'b0, txRun = 1'b1;
    logic [7:0] addr, wrData, rdData, rxTs16Byte = 8'h00;
    logic wrEn, rdEn, lossPin, intRequest;
    logic e1Mode = 0, esfMode = 0, crc4Enable = 0, syncLoss = 0, carrierLoss = 0, unframed = 0;
    logic yellow = 0, nfasStb = 0, nfasBit = 0, sa7Stb = 0, sa7Bit = 1, ts16Stb = 0, rxFrame = 0;
    logic rxMf = 0, crcMf = 0, txFrame = 0, txMf = 0, loopUp = 0, loopDn = 0, spare = 0, ais = 0;
    int nFail = 0, checks = 0, i;
    reg8_t d;

    // ----------------------------------------------------------------
    // clocks, host model and device
    // ----------------------------------------------------------------
    always #12.5 clk = ~clk;
    // line clock stops only when a scenario asks for clock loss
    always #100 if (ckRun) lineCk = ~lineCk;

    host_port_model host_port_model_i (.clk(clk), .addr(addr), .wrEn(wrEn), .rdEn(rdEn),
        .wrData(wrData), .rdData(rdData));

    framer_alarm_event_status framer_alarm_event_status_i (.clk(clk), .reset(reset),
        .addr(addr), .wrEn(wrEn), .rdEn(rdEn), .wrData(wrData), .rdData(rdData),
        .e1Mode(e1Mode), .esfMode(esfMode), .crc4Enable(crc4Enable), .syncLossCond(syncLoss),
        .carrierLossCond(carrierLoss), .unframedOnesCond(unframed), .yellowAlarmCond(yellow),
        .rxNfasStrobe(nfasStb), .rxNfasBit3(nfasBit), .rxSa7Strobe(sa7Stb), .rxSa7Bit(sa7Bit),
        .rxTs16Strobe(ts16Stb), .rxTs16Byte(rxTs16Byte), .rxFrameStrobe(rxFrame),
        .rxMfStart(rxMf), .rxCrcMfBoundary(crcMf), .txFrameStrobe(txFrame), .txMfStart(txMf),
        .loopUpCodeCond(loopUp), .loopDownCodeCond(loopDn), .spareCodeCond(spare),
        .rxAisCiEvt(ais), .rxLineClockIn(lineCk), .txLineClock(lineCk & txRun),
        .lossPin(lossPin), .intRequest(intRequest));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one TS16 byte, then strobes s = {rxFrame, rxMf, crcMf, txFrame, txMf}
    task automatic send_frame(input logic [4:0] s, input reg8_t b);
        {ts16Stb, rxTs16Byte} = {1'b1, b};
        tick(1);
        ts16Stb = 1'b0;
        {rxFrame, rxMf, crcMf, txFrame, txMf} = s;
        tick(1);
        {rxFrame, rxMf, crcMf, txFrame, txMf} = 5'h00;
        tick(3);
    endtask

    task automatic chk(input string what, input reg8_t exp, input reg8_t got);
        checks++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdchk(input reg8_t a, input reg8_t exp, input string what);
        host_port_model_i.read_reg(a, d);
        chk(what, exp, d);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, nFail);
        if (nFail == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        tick(20);
        reset = 1'b0;
        rdchk(8'h1A, 8'h00, "cond status");
        rdchk(8'h1B, 8'h00, "cond mask");
        rdchk(8'h1C, 8'h00, "event status");
        rdchk(8'h1D, 8'h00, "event mask");
        $display("test reset values done");
        // carrier loss: rising edge only, then the clear event alone
        host_port_model_i.write_reg(8'h19, 8'h02);
        tick(1);
        carrierLoss = 1;
        tick(3);
        chk("intRequest", 8'h01, {7'h00, intRequest});
        rdchk(8'h18, 8'h02, "sync status");
        chk("intRequest", 8'h00, {7'h00, intRequest});
        carrierLoss = 0;
        tick(3);
        chk("intRequest", 8'h00, {7'h00, intRequest});
        rdchk(8'h18, 8'h20, "sync status");
        host_port_model_i.write_reg(8'h19, 8'h20);
        tick(1);
        carrierLoss = 1;
        tick(3);
        chk("intRequest", 8'h00, {7'h00, intRequest});
        carrierLoss = 0;
        tick(3);
        chk("intRequest", 8'h01, {7'h00, intRequest});
        rdchk(8'h18, 8'h20, "sync status");
        $display("test sync alarms done");
        // loop-up code in T1: interrupt on both edges
        host_port_model_i.write_reg(8'h1B, 8'h20);
        tick(1);
        loopUp = 1;
        tick(3);
        chk("intRequest", 8'h01, {7'h00, intRequest});
        rdchk(8'h1A, 8'h20, "cond status");
        chk("intRequest", 8'h00, {7'h00, intRequest});
        loopUp = 0;
        tick(3);
        chk("intRequest", 8'h01, {7'h00, intRequest});
        rdchk(8'h1A, 8'h00, "cond status");
        $display("test line conditions done");
        // E1 frame 0 on both sides sets align, multiframe and CRC events
        e1Mode = 1;
        crc4Enable = 1;
        host_port_model_i.write_reg(8'h1D, 8'h04);
        tick(1);
        // a mixed TS16 byte keeps both signaling detectors quiet
        send_frame(5'h1F, 8'h30);
        chk("intRequest", 8'h01, {7'h00, intRequest});
        rdchk(8'h1C, 8'h1F, "event status");
        chk("intRequest", 8'h00, {7'h00, intRequest});
        rdchk(8'h1C, 8'h00, "event status");
        // CRC-4 off: the CRC event follows the rx multiframe count
        crc4Enable = 0;
        send_frame(5'h18, 8'h00);
        rdchk(8'h1C, 8'h27, "event status");
        send_frame(5'h18, 8'hFE);
        rdchk(8'h1C, 8'h47, "event status");
        // two zero Sa7 bits of the last three mark the link
        {sa7Stb, sa7Bit} = 2'b10;
        tick(2);
        sa7Stb = 0;
        rdchk(8'h1A, 8'h04, "cond status");
        {sa7Stb, sa7Bit} = 2'b11;
        tick(2);
        sa7Stb = 0;
        rdchk(8'h1A, 8'h00, "cond status");
        $display("test frame events done");
        // T1 ESF: no boundary at frame 12, one at frame 24; AIS-CI latched
        {e1Mode, esfMode} = 2'b01;
        send_frame(5'h18, 8'hFF);
        rdchk(8'h1C, 8'h04, "event status");
        repeat (23) send_frame(5'h10, 8'hFF);
        rdchk(8'h1C, 8'h00, "event status");
        ais = 1;
        tick(1);
        ais = 0;
        send_frame(5'h10, 8'hFF);
        rdchk(8'h1C, 8'h84, "event status");
        $display("test T1 events done");
        // tx clock stops first, then rx; loss pin follows the tx watchdog
        host_port_model_i.write_reg(8'h70, 8'h01);
        txRun = 0;
        for (i = 0; i < 400 && lossPin !== 1'b1; i++) tick(1);
        chk("lossPin", 8'h01, {7'h00, lossPin});
        if (i < 400) begin
            rdchk(8'h1A, 8'h10, "cond status");
            ckRun = 0;
            tick(250);
            rdchk(8'h1A, 8'h18, "cond status");
            {ckRun, txRun} = 2'b11;
            tick(30);
            chk("lossPin", 8'h00, {7'h00, lossPin});
            rdchk(8'h1A, 8'h00, "cond status");
        end
        $display("test clock loss done");
        report_and_stop();
    end
endmodule
